// [design/cet_timer.sv]
// cascaded 16-bit event timer with APB register slave
// Functional notes
// - cascade-select bit 2 of timer mode chains both counters into 16 bits.
// - count-enable bit 0 of timer mode starts and stops counting.
// - event mode counts each rising or falling edge chosen by clock select.
// - with cascade select set, low counter overflow increments the high counter by one.
// - with cascade select set, both counters matching clears them to zero and raises full-match interrupt.
// - low counter match still raises low-match interrupt and toggles low flip-flop.
// - square-wave enable bit 4 makes each full match invert the output pin.
// - clock code bits 0-3; 0101..1110 divide by 2..1024, 1111 by 4096.
// - free prescaler may delay the first match by up to one count clock.
// - compare value zero is accepted, giving a one-pulse count.
// - compare below count gives no match; counting wraps through overflow.
`timescale 1ns/1ps
`default_nettype none

module cet_timer
  import cet_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cet_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cet_pkg::DATA_W-1:0] pwdata,
  output logic      [cet_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      event_input_pin,
  output logic                           square_wave_pin,
  output logic                           low_channel_out,
  output logic                           irq
);

  import cet_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic              count_enable_bit;
    logic              cascade_select;
    logic [CODE_W-1:0] count_clock_code;
    logic              square_wave_enable;
    logic [CNT_W-1:0]  low_compare;
    logic [CNT_W-1:0]  high_compare;
    logic [CNT_W-1:0]  low_byte_counter;
    logic [CNT_W-1:0]  high_byte_counter;
    logic [PRE_W-1:0]  prescale;
    logic              low_ff;
    logic              sq_pin;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } cet_state_t;

  cet_state_t s;
  cet_state_t next_s;

  logic event_rise;
  logic event_fall;

  ////////////////////////////////////////////////////////////////////////////
  // event pin synchroniser

  cet_edge_sync u_event_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (event_input_pin),
    .rise    (event_rise),
    .fall    (event_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [PRE_W-1:0]  div_mask;
  logic [CODE_W-1:0] div_shift;
  logic              tick;
  logic              low_hit;
  logic              high_hit;
  logic              wr;
  logic              rd_setup;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [DATA_W-1:0] rd_word;
  logic              rd_err;

  always_comb begin
    next_s   = s;
    irq_set  = '0;
    irq_clr  = '0;
    tick     = 1'b0;
    div_shift = '0;
    div_mask = '0;
    rd_word  = '0;
    rd_err   = 1'b0;
    wr       = psel & penable & pwrite;
    rd_setup = psel & ~penable;

    // free-running prescaler, never restarted by enable
    next_s.prescale = PRE_W'(s.prescale + 1'b1);

    // count clock selection
    if (s.count_clock_code == CODE_EVENT_RISE) begin
      tick = event_rise;
    end else if (s.count_clock_code == CODE_EVENT_FALL) begin
      tick = event_fall;
    end else if ((s.count_clock_code >= CODE_DIV_FIRST) && (s.count_clock_code <= CODE_DIV_LAST)) begin
      div_shift = CODE_W'(s.count_clock_code - CODE_SHIFT_OFS);
      div_mask  = PRE_W'(({{(PRE_W-1){1'b0}}, 1'b1} << div_shift) - 1'b1);
      tick      = ((s.prescale & div_mask) == div_mask);
    end else if (s.count_clock_code == CODE_DIV_4096) begin
      div_mask  = PRE_W'(({{(PRE_W-1){1'b0}}, 1'b1} << DIV_4096_SHIFT) - 1'b1);
      tick      = ((s.prescale & div_mask) == div_mask);
    end

    // compare logic; zero compare matches on every count clock
    low_hit  = (s.low_byte_counter == s.low_compare);
    high_hit = (s.high_byte_counter == s.high_compare);

    if (!s.count_enable_bit) begin
      next_s.low_byte_counter  = CNT_ZERO;
      next_s.high_byte_counter = CNT_ZERO;
    end else if (tick) begin
      if (low_hit) begin
        irq_set[IRQ_LOW_MATCH_BIT] = 1'b1;
        next_s.low_ff              = ~s.low_ff;
      end
      if (s.cascade_select) begin
        if (low_hit && high_hit) begin
          next_s.low_byte_counter     = CNT_ZERO;
          next_s.high_byte_counter    = CNT_ZERO;
          irq_set[IRQ_FULL_MATCH_BIT] = 1'b1;
          if (s.square_wave_enable) begin
            next_s.sq_pin = ~s.sq_pin;
          end
        end else begin
          // partial match or compare below count: keep counting and wrap
          next_s.low_byte_counter = CNT_W'(s.low_byte_counter + 1'b1);
          if (s.low_byte_counter == CNT_MAX) begin
            next_s.high_byte_counter = CNT_W'(s.high_byte_counter + 1'b1);
          end
        end
      end else begin
        next_s.high_byte_counter = CNT_ZERO;
        if (low_hit) begin
          next_s.low_byte_counter = CNT_ZERO;
        end else begin
          next_s.low_byte_counter = CNT_W'(s.low_byte_counter + 1'b1);
        end
      end
    end

    // register writes take effect at the access edge
    if (wr) begin
      unique case (paddr)
        ADDR_TIMER_MODE: begin
          next_s.count_enable_bit = pwdata[TMR_COUNT_ENABLE_BIT];
          next_s.cascade_select   = pwdata[TMR_CASCADE_BIT];
        end
        ADDR_CLOCK_SELECT: begin
          next_s.count_clock_code = pwdata[CLK_CODE_LSB +: CODE_W];
        end
        ADDR_OUTPUT_CTRL: begin
          next_s.square_wave_enable = pwdata[OUT_SQ_ENABLE_BIT];
        end
        ADDR_LOW_COMPARE: begin
          next_s.low_compare = pwdata[CNT_W-1:0];
        end
        ADDR_HIGH_COMPARE: begin
          next_s.high_compare = pwdata[CNT_W-1:0];
        end
        ADDR_IRQ_STATUS: begin
          irq_clr = pwdata[IRQ_W-1:0];
        end
        ADDR_IRQ_MASK: begin
          next_s.irq_mask = pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // sticky status, a new event beats a clear in the same cycle
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;

    // read data captured in the setup phase
    unique case (paddr)
      ADDR_TIMER_MODE: begin
        rd_word[TMR_COUNT_ENABLE_BIT] = s.count_enable_bit;
        rd_word[TMR_CASCADE_BIT]      = s.cascade_select;
      end
      ADDR_CLOCK_SELECT: begin
        rd_word[CLK_CODE_LSB +: CODE_W] = s.count_clock_code;
      end
      ADDR_OUTPUT_CTRL: begin
        rd_word[OUT_SQ_ENABLE_BIT] = s.square_wave_enable;
      end
      ADDR_LOW_COMPARE: begin
        rd_word[CNT_W-1:0] = s.low_compare;
      end
      ADDR_HIGH_COMPARE: begin
        rd_word[CNT_W-1:0] = s.high_compare;
      end
      ADDR_COUNT: begin
        rd_word[CNT_W-1:0]                = s.low_byte_counter;
        rd_word[HIGH_BYTE_LSB +: CNT_W]   = s.high_byte_counter;
      end
      ADDR_IRQ_STATUS: begin
        rd_word[IRQ_W-1:0] = s.irq_status;
      end
      ADDR_IRQ_MASK: begin
        rd_word[IRQ_W-1:0] = s.irq_mask;
      end
      ADDR_OUT_STATUS: begin
        rd_word[OUT_LOW_FF_BIT] = s.low_ff;
        rd_word[OUT_SQ_PIN_BIT] = s.sq_pin;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase

    if (rd_setup) begin
      next_s.rdata  = pwrite ? '0 : rd_word;
      next_s.slverr = rd_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s              <= '0;
      s.low_compare  <= CMP_RESET;
      s.high_compare <= CMP_RESET;
      s.irq_mask     <= IRQ_MASK_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready          = psel & penable;
  assign prdata          = s.rdata;
  assign pslverr         = s.slverr & psel & penable;
  assign square_wave_pin = s.sq_pin;
  assign low_channel_out = s.low_ff;
  assign irq             = |(s.irq_status & ~s.irq_mask);

endmodule

`default_nettype wire

// [design/cet_pkg.sv]
// package: register map, field positions and encodings of the cascaded event timer
package cet_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned PRE_W  = 12;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned IRQ_W  = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_TIMER_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_SELECT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_CTRL  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LOW_COMPARE  = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_COMPARE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_COUNT        = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_OUT_STATUS   = 8'h20;

  // field positions
  localparam int unsigned TMR_COUNT_ENABLE_BIT = 0;
  localparam int unsigned TMR_CASCADE_BIT      = 2;
  localparam int unsigned OUT_SQ_ENABLE_BIT    = 4;
  localparam int unsigned CLK_CODE_LSB         = 0;
  localparam int unsigned IRQ_LOW_MATCH_BIT    = 0;
  localparam int unsigned IRQ_FULL_MATCH_BIT   = 1;
  localparam int unsigned OUT_LOW_FF_BIT       = 0;
  localparam int unsigned OUT_SQ_PIN_BIT       = 1;
  localparam int unsigned HIGH_BYTE_LSB        = 8;

  // count clock codes and divider shifts
  localparam logic [CODE_W-1:0] CODE_EVENT_FALL = 4'h0;
  localparam logic [CODE_W-1:0] CODE_EVENT_RISE = 4'h1;
  localparam logic [CODE_W-1:0] CODE_DIV_FIRST  = 4'h5;
  localparam logic [CODE_W-1:0] CODE_DIV_LAST   = 4'hE;
  localparam logic [CODE_W-1:0] CODE_DIV_4096   = 4'hF;
  localparam logic [CODE_W-1:0] CODE_SHIFT_OFS  = 4'h4;
  localparam logic [CODE_W-1:0] DIV_4096_SHIFT  = 4'hC;

  // reset values and counter limits
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO       = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX        = 8'hFF;
  localparam logic [CNT_W-1:0] CMP_RESET      = 8'hFF;

endpackage

// [design/cet_edge_sync.sv]
// three-flop pin synchroniser with filtered rising and falling edge pulses
`timescale 1ns/1ps
`default_nettype none

module cet_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } cet_sync_state_t;

  cet_sync_state_t s;
  cet_sync_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.s1    = pin;
    next_s.s2    = s.s1;
    next_s.s3    = s.s2;
    next_s.rise  = 1'b0;
    next_s.fall  = 1'b0;
    // a change counts once the second and third stage agree
    if ((s.s2 == s.s3) && (s.s3 != s.level)) begin
      next_s.level = s.s3;
      next_s.rise  = s.s3;
      next_s.fall  = ~s.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

endmodule

`default_nettype wire

// [test/cet_pulse_src.sv]
// external pulse source model feeding the event input pin
`timescale 1ns/1ps
`default_nettype none

module cet_pulse_src (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;

  // whole pulses, 4 cycles high then 4 low, idle low
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk) pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

// [test/cet_timer_properties.sv]
// concurrent checks on the timer's ports
`timescale 1ns/1ps
`default_nettype none

module cet_timer_properties (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [cet_pkg::ADDR_W-1:0] paddr,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       square_wave_pin,
  input wire logic                       low_channel_out,
  input wire logic                       irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  chk_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
    else $error("no error on unmapped address");
  chk_sq_with_low: assert property ($changed(square_wave_pin) |-> $changed(low_channel_out))
    else $error("square toggle without low match");
  chk_low_spacing: assert property ($changed(low_channel_out) |=> $stable(low_channel_out))
    else $error("low toggles faster than tick");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(psel && penable && pwrite) ||
    $changed(low_channel_out))
    else $error("irq rose without cause");
  chk_irq_fall_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
  chk_reset_outs: assert property ($rose(presetn) |-> !square_wave_pin && !low_channel_out && !irq)
    else $error("outputs not idle after reset");

  cover property ($changed(square_wave_pin));
  cover property ($rose(irq));
  cover property (pslverr);
endmodule

bind cet_timer cet_timer_properties u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .square_wave_pin(square_wave_pin),
  .low_channel_out(low_channel_out), .irq(irq));

`default_nettype wire

// [test/cet_timer_tb_top.sv]
// self-checking testbench of the cascaded event timer
`timescale 1ns/1ps
`default_nettype none

module cet_timer_tb_top;
  import cet_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic        pready, pslverr, rerr, pin, sq, lo, irq;
  int          n_errors = 0, n_compared = 0;

  always #5 pclk = ~pclk;

  cet_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_input_pin(pin), .square_wave_pin(sq), .low_channel_out(lo), .irq(irq));
  cet_pulse_src u_src (.clk(pclk), .pin(pin));

  //////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    // no local limit: a hung bus is ended by the watchdog
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(0, a, '0);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(ADDR_IRQ_MASK);     chk("mask", rdat, 32'h3);
    rd(ADDR_LOW_COMPARE);  chk("low cmp", rdat, 32'hFF);
    rd(ADDR_HIGH_COMPARE); chk("high cmp", rdat, 32'hFF);
    rd(8'h40); chk("unmapped", rdat, 0); chk("err", rerr, 1);
    $display("reset test done");
  endtask

  // cycles between two square-wave toggles
  task automatic t_period(input logic [15:0] cmp, input logic [3:0] code);
    int c, k, dv;
    logic s;
    dv = (code == 4'hF) ? 4096 : (1 << (code - 4));
    wr(ADDR_TIMER_MODE, 0);
    wr(ADDR_LOW_COMPARE, cmp[7:0]);
    wr(ADDR_HIGH_COMPARE, cmp[15:8]);
    wr(ADDR_CLOCK_SELECT, code);
    wr(ADDR_OUTPUT_CTRL, 32'h10);
    wr(ADDR_TIMER_MODE, 5);
    k = 0;
    s = sq;
    while (sq === s && k < 40000) begin @(posedge pclk); k++; end
    c = 0;
    s = sq;
    while (sq === s && c < 40000) begin @(posedge pclk); c++; end
    chk("period", c, (cmp + 1) * dv);
    $display("period test done");
  endtask

  task automatic t_event;
    wr(ADDR_TIMER_MODE, 0);
    rd(ADDR_COUNT); chk("stopped count", rdat, 0);
    wr(ADDR_CLOCK_SELECT, CODE_EVENT_RISE);
    wr(ADDR_LOW_COMPARE, 8'hFF);
    wr(ADDR_HIGH_COMPARE, 8'hFF);
    wr(ADDR_TIMER_MODE, 5);
    u_src.pulses(258);
    repeat (10) @(posedge pclk);
    rd(ADDR_COUNT); chk("rise count", rdat, 32'h0102);
    wr(ADDR_TIMER_MODE, 0);
    wr(ADDR_CLOCK_SELECT, CODE_EVENT_FALL);
    wr(ADDR_TIMER_MODE, 5);
    u_src.pulses(2);
    repeat (10) @(posedge pclk);
    rd(ADDR_COUNT); chk("fall count", rdat, 2);
    $display("event test done");
  endtask

  task automatic t_irq;
    wr(ADDR_TIMER_MODE, 0);
    wr(ADDR_LOW_COMPARE, 0);
    wr(ADDR_HIGH_COMPARE, 0);
    wr(ADDR_CLOCK_SELECT, CODE_DIV_FIRST);
    wr(ADDR_TIMER_MODE, 5);
    repeat (20) @(posedge pclk);
    chk("irq masked", irq, 0);
    rd(ADDR_IRQ_STATUS); chk("status", rdat, 3);
    wr(ADDR_IRQ_MASK, 1);
    @(posedge pclk);
    chk("irq on", irq, 1);
    wr(ADDR_TIMER_MODE, 0);
    wr(ADDR_IRQ_STATUS, 3);
    rd(ADDR_IRQ_STATUS); chk("cleared", rdat, 0);
    chk("irq off", irq, 0);
    $display("irq test done");
  endtask

  // eight-bit mode: low counter alone; a lowered compare wraps through overflow
  task automatic t_low;
    int c, k;
    logic l;
    logic [31:0] c1;
    wr(ADDR_TIMER_MODE, 0);
    wr(ADDR_IRQ_STATUS, 3);
    wr(ADDR_LOW_COMPARE, 3);
    wr(ADDR_CLOCK_SELECT, CODE_DIV_FIRST);
    wr(ADDR_TIMER_MODE, 1);
    k = 0;
    l = lo;
    while (lo === l && k < 100) begin @(posedge pclk); k++; end
    c = 0;
    l = lo;
    while (lo === l && c < 100) begin @(posedge pclk); c++; end
    chk("low period", c, 8);
    wr(ADDR_TIMER_MODE, 0);
    rd(ADDR_IRQ_STATUS); chk("low only", rdat, 1);
    rd(ADDR_OUT_STATUS); chk("out status", rdat, {sq, lo});
    wr(ADDR_LOW_COMPARE, 8'h40);
    wr(ADDR_TIMER_MODE, 1);
    repeat (80) @(posedge pclk);
    wr(ADDR_LOW_COMPARE, 8'h10);
    rd(ADDR_COUNT);
    c1 = rdat;
    chk("high held", c1[15:8], 0);
    l = lo;
    repeat (60) @(posedge pclk);
    chk("no early match", lo, l);
    rd(ADDR_COUNT); chk("still rising", rdat > c1, 1);
    k = 0;
    while (lo === l && k < 600) begin @(posedge pclk); k++; end
    chk("wrap match", lo !== l, 1);
    wr(ADDR_TIMER_MODE, 0);
    $display("low channel test done");
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    // tests need about 37000 cycles
    repeat (80000) @(posedge pclk);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_period(16'h0001, 4'h5);
    t_period(16'h0100, 4'h5);
    t_period(16'h0000, 4'h6);
    t_period(16'h0003, 4'hE);
    t_period(16'h0002, 4'hF);
    t_event();
    t_irq();
    t_low();
    complete_run();
  end
endmodule

`default_nettype wire
